/* sks_pkg.sv */
package sks_pkg;

  localparam int          ACC_W        = 24;
  localparam int          PC_W         = 16;
  localparam int          LEN_W        = 4;
  localparam int          CYC_W        = 8;
  localparam int          BIT_IDX_W    = 5;

  localparam logic [23:0] SIGN_POS_VAL = 24'h000001;
  localparam logic [23:0] SIGN_NEG_VAL = 24'hFFFFFF;
  localparam logic [4:0]  BIT_IDX_MAX  = 5'h17;
  localparam logic [1:0]  SKIP_N_NONE  = 2'h0;
  localparam logic [15:0] SIGN_BYTES   = 16'h0002;
  localparam logic [15:0] SKIP_BYTES   = 16'h0001;
  localparam logic [7:0]  CYC_ONE      = 8'h01;
  localparam logic [1:0]  REMAIN_ONE   = 2'h1;

  typedef enum logic [3:0] {
    OP_NONE                        = 4'h0,
    OP_SIGN                        = 4'h1,
    OP_JUMP_OVER                   = 4'h2,
    OP_JUMP_OVER_IF_BIT_LOW        = 4'h3,
    OP_JUMP_OVER_IF_BIT_HIGH       = 4'h4,
    OP_JUMP_OVER_IF_CARRY_LOW      = 4'h5,
    OP_JUMP_OVER_IF_CARRY_HIGH     = 4'h6,
    OP_JUMP_OVER_IF_RESULT_ZERO    = 4'h7,
    OP_JUMP_OVER_IF_RESULT_NONZERO = 4'h8
  } sks_op_t;

  typedef enum logic [1:0] {
    ACC_X = 2'b00,
    ACC_Y = 2'b01,
    ACC_Z = 2'b10,
    ACC_R = 2'b11
  } sks_acc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SIGN = 2'b01,
    ST_SKIP = 2'b10
  } sks_state_t;

  function automatic logic [23:0] sks_pick_acc(
    input sks_acc_t    sel,
    input logic [23:0] ax,
    input logic [23:0] ay,
    input logic [23:0] az,
    input logic [23:0] ar
  );
    logic [23:0] v;
    v = ax;
    case (sel)
      ACC_Y:   v = ay;
      ACC_Z:   v = az;
      ACC_R:   v = ar;
      default: v = ax;
    endcase
    return v;
  endfunction : sks_pick_acc

endpackage : sks_pkg

/* sks_sign.sv */
`timescale 1ns/1ps
`default_nettype none
module sks_sign (
  input  wire logic [sks_pkg::ACC_W-1:0] value_in,
  output logic      [sks_pkg::ACC_W-1:0] result_out,
  output logic                           negative_out
);
  import sks_pkg::*;

  // Zero counts as positive
  assign negative_out = value_in[ACC_W-1];
  assign result_out   = negative_out ? SIGN_NEG_VAL : SIGN_POS_VAL;
endmodule : sks_sign
`default_nettype wire

/* sks_cond.sv */
`timescale 1ns/1ps
`default_nettype none
module sks_cond (
  input  wire sks_pkg::sks_op_t                op_in,
  input  wire logic [sks_pkg::ACC_W-1:0]       value_in,
  input  wire logic [sks_pkg::BIT_IDX_W-1:0]   bit_idx_in,
  input  wire logic                            carry_in,
  input  wire logic                            nonzero_in,
  output logic                                 is_skip_out,
  output logic                                 take_out
);
  import sks_pkg::*;

  logic bit_ok;
  logic bit_val;

  // Index past the top bit never skips, so a bad operand cannot hide code
  assign bit_ok  = (bit_idx_in <= BIT_IDX_MAX);
  assign bit_val = bit_ok ? value_in[bit_idx_in] : 1'b0;

  always_comb begin
    is_skip_out = 1'b1;
    take_out    = 1'b0;
    case (op_in)
      OP_JUMP_OVER:                   take_out = 1'b1;
      OP_JUMP_OVER_IF_BIT_LOW:        take_out = bit_ok & ~bit_val;
      OP_JUMP_OVER_IF_BIT_HIGH:       take_out = bit_ok & bit_val;
      OP_JUMP_OVER_IF_CARRY_LOW:      take_out = ~carry_in;
      OP_JUMP_OVER_IF_CARRY_HIGH:     take_out = carry_in;
      OP_JUMP_OVER_IF_RESULT_ZERO:    take_out = ~nonzero_in;
      OP_JUMP_OVER_IF_RESULT_NONZERO: take_out = nonzero_in;
      default:                        is_skip_out = 1'b0;
    endcase
  end
endmodule : sks_cond
`default_nettype wire

/* sks_exec.sv */
// Functional notes
// - Sign writes one for zero or positive
// - Sign writes all ones for negative
// - Sign: any accumulator, two bytes, two cycles
// - Plain skip passes next one to three
// - Skip is one byte, one cycle plus skipped
// - Skip when chosen accumulator bit is zero
// - Skip when chosen accumulator bit is one
// - Skip when carry flag is zero
// - Skip when carry flag is one
// - Skip when nonzero flag is zero
// - Skip when nonzero flag is one
`timescale 1ns/1ps
`default_nettype none
module sks_exec (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          op_valid_in,
  input  wire sks_pkg::sks_op_t              op_in,
  input  wire sks_pkg::sks_acc_t             acc_sel_in,
  input  wire logic [sks_pkg::BIT_IDX_W-1:0] bit_idx_in,
  input  wire logic [1:0]                    skip_n_in,
  input  wire logic [sks_pkg::ACC_W-1:0]     acc_x_in,
  input  wire logic [sks_pkg::ACC_W-1:0]     acc_y_in,
  input  wire logic [sks_pkg::ACC_W-1:0]     acc_z_in,
  input  wire logic [sks_pkg::ACC_W-1:0]     acc_r_in,
  input  wire logic                          carry_in,
  input  wire logic                          nonzero_in,
  input  wire logic [sks_pkg::PC_W-1:0]      pc_in,
  input  wire logic [sks_pkg::LEN_W-1:0]     peek_len_in,
  input  wire logic [sks_pkg::CYC_W-1:0]     peek_cycles_in,
  output logic                               busy_out,
  output logic                               skipping_out,
  output logic      [sks_pkg::PC_W-1:0]      peek_addr_out,
  output logic                               pc_step_valid_out,
  output logic      [sks_pkg::PC_W-1:0]      pc_step_out,
  output logic                               acc_wr_out,
  output sks_pkg::sks_acc_t                  acc_wr_sel_out,
  output logic      [sks_pkg::ACC_W-1:0]     acc_wr_data_out,
  output logic                               flag_wr_out,
  output logic                               sign_flag_out,
  output logic                               nonzero_flag_out
);
  import sks_pkg::*;

  sks_state_t         state;
  sks_state_t         next_state;
  logic [1:0]         remain;
  logic [1:0]         next_remain;
  logic [PC_W-1:0]    offset;
  logic [PC_W-1:0]    next_offset;
  logic [CYC_W-1:0]   cnt;
  logic [CYC_W-1:0]   next_cnt;
  logic               next_pc_step_valid;
  logic [PC_W-1:0]    next_pc_step;
  logic               next_acc_wr;
  sks_acc_t           next_acc_wr_sel;
  logic [ACC_W-1:0]   next_acc_wr_data;
  logic               next_flag_wr;
  logic               next_sign_flag;
  logic               next_nonzero_flag;

  logic [ACC_W-1:0]   picked;
  logic [ACC_W-1:0]   sign_val;
  logic               sign_neg;
  logic               is_skip;
  logic               take;
  logic               accept;
  logic [PC_W-1:0]    past_peek;
  logic [CYC_W-1:0]   cnt_inc;

  assign picked = sks_pick_acc(acc_sel_in, acc_x_in, acc_y_in, acc_z_in, acc_r_in);

  sks_sign u_sign (
    .value_in     (picked),
    .result_out   (sign_val),
    .negative_out (sign_neg)
  );

  sks_cond u_cond (
    .op_in       (op_in),
    .value_in    (picked),
    .bit_idx_in  (bit_idx_in),
    .carry_in    (carry_in),
    .nonzero_in  (nonzero_in),
    .is_skip_out (is_skip),
    .take_out    (take)
  );

  // Core takes no op while busy; ops offered then are ignored
  assign busy_out      = (state != ST_IDLE);
  assign skipping_out  = (state == ST_SKIP);
  assign accept        = op_valid_in && (state == ST_IDLE);
  assign peek_addr_out = PC_W'(pc_in + offset);
  assign past_peek     = PC_W'(offset + {{(PC_W-LEN_W){1'b0}}, peek_len_in});
  assign cnt_inc       = CYC_W'(cnt + CYC_ONE);

  always_comb begin
    next_state         = state;
    next_remain        = remain;
    next_offset        = offset;
    next_cnt           = cnt;
    next_pc_step_valid = 1'b0;
    next_pc_step       = pc_step_out;
    next_acc_wr        = 1'b0;
    next_acc_wr_sel    = acc_wr_sel_out;
    next_acc_wr_data   = acc_wr_data_out;
    next_flag_wr       = 1'b0;
    next_sign_flag     = sign_flag_out;
    next_nonzero_flag  = nonzero_flag_out;
    case (state)
      ST_IDLE: begin
        if (accept && op_in == OP_SIGN) begin
          // Result lands in the second cycle, the flags with it
          next_state         = ST_SIGN;
          next_acc_wr        = 1'b1;
          next_acc_wr_sel    = acc_sel_in;
          next_acc_wr_data   = sign_val;
          next_flag_wr       = 1'b1;
          next_sign_flag     = sign_neg;
          next_nonzero_flag  = 1'b1;
          next_pc_step_valid = 1'b1;
          next_pc_step       = SIGN_BYTES;
        end else if (accept && is_skip) begin
          if (take && skip_n_in != SKIP_N_NONE) begin
            next_state  = ST_SKIP;
            next_remain = skip_n_in;
            next_offset = SKIP_BYTES;
            next_cnt    = '0;
          end else begin
            // Not taken: one cycle, one byte, flags untouched
            next_pc_step_valid = 1'b1;
            next_pc_step       = SKIP_BYTES;
          end
        end
      end
      ST_SIGN: begin
        next_state = ST_IDLE;
      end
      ST_SKIP: begin
        // Burn the cycles of each passed instruction without running it
        if (cnt_inc >= peek_cycles_in) begin
          next_cnt = '0;
          if (remain == REMAIN_ONE) begin
            next_state         = ST_IDLE;
            next_pc_step_valid = 1'b1;
            next_pc_step       = past_peek;
          end else begin
            next_remain = 2'(remain - REMAIN_ONE);
            next_offset = past_peek;
          end
        end else begin
          next_cnt = cnt_inc;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state             <= ST_IDLE;
      remain            <= '0;
      offset            <= '0;
      cnt               <= '0;
      pc_step_valid_out <= 1'b0;
      pc_step_out       <= '0;
      acc_wr_out        <= 1'b0;
      acc_wr_sel_out    <= ACC_X;
      acc_wr_data_out   <= '0;
      flag_wr_out       <= 1'b0;
      sign_flag_out     <= 1'b0;
      nonzero_flag_out  <= 1'b0;
    end else begin
      state             <= next_state;
      remain            <= next_remain;
      offset            <= next_offset;
      cnt               <= next_cnt;
      pc_step_valid_out <= next_pc_step_valid;
      pc_step_out       <= next_pc_step;
      acc_wr_out        <= next_acc_wr;
      acc_wr_sel_out    <= next_acc_wr_sel;
      acc_wr_data_out   <= next_acc_wr_data;
      flag_wr_out       <= next_flag_wr;
      sign_flag_out     <= next_sign_flag;
      nonzero_flag_out  <= next_nonzero_flag;
    end
  end
endmodule : sks_exec
`default_nettype wire

/* sks_exec_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sks_exec_props (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             op_valid_in,
  input  wire sks_pkg::sks_op_t op_in,
  input  wire sks_pkg::sks_acc_t acc_sel_in,
  input  wire logic [4:0]       bit_idx_in,
  input  wire logic [1:0]       skip_n_in,
  input  wire logic [23:0]      acc_x_in,
  input  wire logic [23:0]      acc_y_in,
  input  wire logic [23:0]      acc_z_in,
  input  wire logic [23:0]      acc_r_in,
  input  wire logic             carry_in,
  input  wire logic             nonzero_in,
  input  wire logic             busy_out,
  input  wire logic             skipping_out,
  input  wire logic             pc_step_valid_out,
  input  wire logic [15:0]      pc_step_out,
  input  wire logic             acc_wr_out,
  input  wire sks_pkg::sks_acc_t acc_wr_sel_out,
  input  wire logic [23:0]      acc_wr_data_out,
  input  wire logic             flag_wr_out
);
  import sks_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [23:0] v;
  logic        take;
  logic        sign_take;
  logic        cond;
  assign v = acc_sel_in == ACC_Y ? acc_y_in : acc_sel_in == ACC_Z ? acc_z_in :
             acc_sel_in == ACC_R ? acc_r_in : acc_x_in;
  assign take = op_valid_in && !busy_out;
  assign sign_take = take && op_in == OP_SIGN;
  always_comb begin
    case (op_in)
      OP_JUMP_OVER:                   cond = 1'b1;
      OP_JUMP_OVER_IF_BIT_LOW:        cond = bit_idx_in <= BIT_IDX_MAX && !v[bit_idx_in];
      OP_JUMP_OVER_IF_BIT_HIGH:       cond = bit_idx_in <= BIT_IDX_MAX && v[bit_idx_in];
      OP_JUMP_OVER_IF_CARRY_LOW:      cond = !carry_in;
      OP_JUMP_OVER_IF_CARRY_HIGH:     cond = carry_in;
      OP_JUMP_OVER_IF_RESULT_ZERO:    cond = !nonzero_in;
      OP_JUMP_OVER_IF_RESULT_NONZERO: cond = nonzero_in;
      default:                        cond = 1'b0;
    endcase
  end
  sequence s_skip_take;
    take && op_in inside {[OP_JUMP_OVER:OP_JUMP_OVER_IF_RESULT_NONZERO]};
  endsequence
  a_sign_pos_one: assert property ((sign_take && !v[23]) |=> acc_wr_out &&
    acc_wr_data_out == SIGN_POS_VAL && acc_wr_sel_out == $past(acc_sel_in)) else $error("sign pos");
  a_sign_neg_ones: assert property ((sign_take && v[23]) |=> acc_wr_out &&
    acc_wr_data_out == SIGN_NEG_VAL) else $error("sign neg");
  a_sign_two_cycles: assert property (sign_take |=> busy_out && flag_wr_out &&
    pc_step_valid_out && pc_step_out == SIGN_BYTES ##1 !busy_out) else $error("sign timing");
  a_skip_taken_busy: assert property ((s_skip_take ##0 (skip_n_in != 0 && cond)) |=>
    skipping_out && !pc_step_valid_out) else $error("skip not entered");
  a_skip_not_taken: assert property ((s_skip_take ##0 !(skip_n_in != 0 && cond)) |=>
    !busy_out && pc_step_valid_out && pc_step_out == SKIP_BYTES) else $error("skip wrongly taken");
  a_skip_end_step: assert property ($fell(skipping_out) |-> pc_step_valid_out && !busy_out)
    else $error("skip end");
  a_skip_inert_flags: assert property (skipping_out |-> !acc_wr_out && !flag_wr_out)
    else $error("write while skipping");
  a_write_cause: assert property (acc_wr_out |-> $past(sign_take))
    else $error("stray write");
endmodule : sks_exec_props
bind sks_exec sks_exec_props u_props (.*);
`default_nettype wire

/* sign_and_skip_execution_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sign_and_skip_execution_tb;
  import sks_pkg::*;
  logic        sys_clk_in = 0, rst_in = 1, op_valid_in = 0, carry_in = 0, nonzero_in = 0;
  sks_op_t     op_in = OP_NONE;
  sks_acc_t    acc_sel_in = ACC_X, acc_wr_sel_out;
  logic [4:0]  bit_idx_in = 0;
  logic [1:0]  skip_n_in = 0;
  logic [23:0] acc_x_in = 0, acc_y_in = 0, acc_z_in = 0, acc_r_in = 0, acc_wr_data_out;
  logic [15:0] pc_in = 0, peek_addr_out, pc_step_out;
  logic [3:0]  peek_len_in;
  logic [7:0]  peek_cycles_in;
  logic        busy_out, skipping_out, pc_step_valid_out, acc_wr_out;
  logic        flag_wr_out, sign_flag_out, nonzero_flag_out;
  int          fails = 0, cmp_count = 0;
  logic [31:0] rng = 32'hACF3;
  always #25 sys_clk_in = ~sys_clk_in;
  // Instruction lengths and cycle counts vary with address, zero cycles included
  assign peek_len_in = {2'h0, peek_addr_out[1:0]} + 4'h1;
  assign peek_cycles_in = {6'h00, peek_addr_out[3:2]};
  sks_exec DUT (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("fails %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic run_op(input sks_op_t op);
    logic [23:0] v;
    logic [15:0] a, st;
    logic        tk;
    int          cyc, k;
    v = acc_sel_in == ACC_Y ? acc_y_in : acc_sel_in == ACC_Z ? acc_z_in :
        acc_sel_in == ACC_R ? acc_r_in : acc_x_in;
    case (op)
      OP_JUMP_OVER_IF_BIT_LOW:     tk = bit_idx_in <= 5'h17 && !v[bit_idx_in];
      OP_JUMP_OVER_IF_BIT_HIGH:    tk = bit_idx_in <= 5'h17 && v[bit_idx_in];
      OP_JUMP_OVER_IF_CARRY_LOW:   tk = !carry_in;
      OP_JUMP_OVER_IF_CARRY_HIGH:  tk = carry_in;
      OP_JUMP_OVER_IF_RESULT_ZERO: tk = !nonzero_in;
      OP_JUMP_OVER_IF_RESULT_NONZERO: tk = nonzero_in;
      default:                     tk = 1'b1;
    endcase
    tk = tk && skip_n_in != 2'h0;
    a = pc_in + 16'h1;
    st = 16'h1;
    cyc = 0;
    for (int i = 0; i < skip_n_in; i++) begin
      st += a[1:0] + 16'h1;
      cyc += (a[3:2] == 2'h0) ? 1 : a[3:2];
      a += a[1:0] + 16'h1;
    end
    op_in = op;
    op_valid_in = 1;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    op_valid_in = 0;
    if (op == OP_SIGN) begin
      chk("acc_data", acc_wr_data_out, v[23] ? 24'hFFFFFF : 24'h000001);
      chk("acc_wr", {acc_wr_out, acc_wr_sel_out}, {1'b1, acc_sel_in});
      chk("flags", {flag_wr_out, sign_flag_out, nonzero_flag_out}, {1'b1, v[23], 1'b1});
      chk("sign_step", {busy_out, pc_step_valid_out, pc_step_out}, 18'h30002);
      @(negedge sys_clk_in);
      chk("sign_busy", busy_out, 0);
    end else begin
      k = 0;
      while (busy_out && k < 100) begin
        chk("skip_inert", {skipping_out, acc_wr_out, flag_wr_out}, 24'h000004);
        k++;
        @(negedge sys_clk_in);
      end
      chk("skip_cycles", k[23:0], tk ? cyc[23:0] : 24'h0);
      chk("skip_step", {pc_step_valid_out, pc_step_out}, {1'b1, tk ? st : 16'h1});
      chk("skip_writes", {acc_wr_out, flag_wr_out}, 0);
    end
    // Idle cycle between ops, so op_valid_in never drops and rises in one step
    @(negedge sys_clk_in);
    chk("pulse_end", {pc_step_valid_out, acc_wr_out, flag_wr_out}, 24'h000000);
  endtask : run_op
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    fails++;
    close_out();
  end
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rst_in = 0;
    @(negedge sys_clk_in);
    for (int i = 0; i < 24; i++) begin
      acc_sel_in = sks_acc_t'(i % 4);
      acc_x_in = (i % 4 == 0) ? 24'h0 : (i % 4 == 1) ? 24'h7FFFFF : 24'h800000;
      {acc_y_in, acc_z_in, acc_r_in} = {acc_x_in, acc_x_in, 24'hFFFFFF};
      run_op(OP_SIGN);
    end
    // Random mix; bit index above 23 and zero count appear among it
    for (int n = 0; n < 400; n++) begin
      rng = xs(rng);
      acc_x_in = rng[23:0];
      acc_sel_in = sks_acc_t'(rng[25:24]);
      rng = xs(rng);
      acc_y_in = rng[23:0];
      {carry_in, nonzero_in} = rng[25:24];
      rng = xs(rng);
      acc_z_in = rng[23:0];
      bit_idx_in = rng[28:24];
      rng = xs(rng);
      acc_r_in = rng[23:0];
      skip_n_in = rng[25:24];
      pc_in = rng[31:16];
      // Four bits wide so the code runs 1 to 8 and never wraps to the idle code
      run_op(sks_op_t'({1'b0, rng[29:27]} + 4'h1));
    end
    close_out();
  end
endmodule : sign_and_skip_execution_tb
`default_nettype wire
